// File: hw/pfid_regs.sv
// profiling buffer information and sampling event filter registers
// assumes requests and samples come from logic on mclk; filter control lives elsewhere
//
// Summary of operation
// - buffer information read at lowest level is undefined; other levels read normally
// - buffer information decodes at 3,0,c9,c10,7 and is 64 bits
// - event filter decodes at 3,0,c9,c9,5 and is 64 bits
// - sampling capability information decodes at 3,0,c9,c9,7 and is 64 bits
// - buffer information bit 5 reads one: flag management like explicit accesses
// - bit 4 reads one when buffer owned higher or other security state
// - bits 3 to 0 read 6, 64-byte alignment, records padded to that
// - overall filter is the AND of all per-event filters
// - set filter bit drops samples whose matching event is zero
// - clear filter bit leaves its event without influence
// - unimplemented or unfilterable event bits read zero and ignore writes
// - all filter bits ignored while filter enable is zero
// - multi-bit implementation events use their bit group as their filter
// - event 3 is level 1 cache refill, event 5 is table walk
// - every lower bit filters the event of the same number
`timescale 1ns/100ps
`default_nettype none
`include "pfid_consts.svh"

module pfid_regs #(
  parameter logic [63:0] IMPL_MASK = `PFID_IMPL_MASK,
  parameter logic [63:0] CAP_VALUE = `PFID_CAP_VALUE
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // system register access
  input wire pfid_pkg::pfid_req_t req,
  output var pfid_pkg::pfid_rsp_t rsp,
  // buffer ownership and filter control
  input wire logic buffer_owned_higher,
  input wire logic filter_enable_bit,
  // samples
  input wire logic sample_valid,
  input wire logic [63:0] sample_events,
  output logic sample_done,
  output logic sample_keep
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic base_hit;
  wire logic info_hit;
  wire logic filt_hit;
  wire logic cap_hit;
  wire logic any_hit;
  wire logic lowest_el;
  wire logic info_undef;
  wire logic filt_wr;
  wire logic [63:0] info_value;
  wire logic [63:0] sel_rdata;
  wire logic [63:0] pass;
  wire logic next_keep;
  logic [63:0] sample_event_filter;

  assign base_hit = req.op0 == `PFID_OP0 && req.op1 == `PFID_OP1 && req.crn == `PFID_CRN;
  assign info_hit = base_hit && req.crm == `PFID_INFO_CRM && req.op2 == `PFID_INFO_OP2;
  assign filt_hit = base_hit && req.crm == `PFID_FILT_CRM && req.op2 == `PFID_FILT_OP2;
  assign cap_hit = base_hit && req.crm == `PFID_CAP_CRM && req.op2 == `PFID_CAP_OP2;
  assign any_hit = info_hit | filt_hit | cap_hit;
  assign lowest_el = req.el == `PFID_EL_LOWEST;
  // the lowest level may not touch any of these; its reads and writes of all three are undefined
  assign info_undef = any_hit && lowest_el;
  // info and capability have no write path at all
  assign filt_wr = req.valid && req.write && filt_hit && !lowest_el;

  // ---------------------------------------------------------------
  // buffer information value, constant apart from ownership
  // ---------------------------------------------------------------
  assign info_value = {58'h0,
    `PFID_INFO_FLAG_VAL,
    buffer_owned_higher,
    `PFID_INFO_ALIGN_VAL};

  assign sel_rdata = (info_undef || !req.valid || req.write) ? 64'h0 :
    info_hit ? info_value :
    filt_hit ? sample_event_filter :
    cap_hit ? CAP_VALUE : 64'h0;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      sample_event_filter <= `PFID_FILT_RESET;
    end else if (filt_wr) begin
      sample_event_filter <= req.wdata & IMPL_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rsp <= '0;
    end else begin
      rsp.ack <= req.valid;
      rsp.hit <= req.valid && any_hit;
      rsp.undef <= req.valid && info_undef;
      rsp.rdata <= sel_rdata;
    end
  end

  // ---------------------------------------------------------------
  // sample filter
  // ---------------------------------------------------------------
  // a multi-bit event simply uses several cells; each bit of its group must match
  genvar g;
  generate
    for (g = 0; g < 64; g++) begin : g_cell
      pfid_filter_bit u_cell (
        .armed(sample_event_filter[g]),
        .event_seen(sample_events[g]),
        .pass(pass[g])
      );
    end
  endgenerate

  assign next_keep = !filter_enable_bit || (&pass);

  always_ff @(posedge mclk) begin
    if (rst) begin
      sample_done <= 1'h0;
      sample_keep <= 1'h0;
    end else begin
      sample_done <= sample_valid;
      sample_keep <= sample_valid && next_keep;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_info_undef;
    req.valid && !req.write && info_hit && lowest_el |=> rsp.undef && rsp.rdata == 64'h0;
  endproperty
  a_info_undef: assert property (p_info_undef) else $error("lowest level info read not undefined");

  property p_info_read;
    req.valid && !req.write && info_hit && !lowest_el |=> !rsp.undef && rsp.hit
      && rsp.rdata[3:0] == 4'h6 && rsp.rdata[5] && rsp.rdata[63:6] == 58'h0;
  endproperty
  a_info_read: assert property (p_info_read) else $error("info read value wrong");

  property p_info_own;
    req.valid && !req.write && info_hit && !lowest_el |=> rsp.rdata[4] == $past(buffer_owned_higher);
  endproperty
  a_info_own: assert property (p_info_own) else $error("ownership bit wrong");

  property p_filt_wr;
    filt_wr ##1 (req.valid && !req.write && filt_hit && !lowest_el) |=>
      rsp.rdata == ($past(req.wdata, 2) & IMPL_MASK);
  endproperty
  a_filt_wr: assert property (p_filt_wr) else $error("filter write readback wrong");

  property p_info_nowrite;
    req.valid && req.write && info_hit |=> $stable(sample_event_filter);
  endproperty
  a_info_nowrite: assert property (p_info_nowrite) else $error("info write changed state");

  property p_disabled;
    sample_valid && !filter_enable_bit |=> sample_keep;
  endproperty
  a_disabled: assert property (p_disabled) else $error("sample dropped with filter off");

  property p_drop;
    sample_valid && filter_enable_bit && |(sample_event_filter & ~sample_events) |=> sample_done && !sample_keep;
  endproperty
  a_drop: assert property (p_drop) else $error("sample missing event kept");

  property p_keep;
    sample_valid && filter_enable_bit && ((sample_event_filter & ~sample_events) == 64'h0) |=> sample_keep;
  endproperty
  a_keep: assert property (p_keep) else $error("matching sample dropped");

  property p_cap;
    req.valid && !req.write && cap_hit && !lowest_el |=> rsp.hit && rsp.rdata == CAP_VALUE;
  endproperty
  a_cap: assert property (p_cap) else $error("capability read wrong");

  property p_lowest_nowrite;
    req.valid && req.write && filt_hit && lowest_el |=> rsp.undef && $stable(sample_event_filter);
  endproperty
  a_lowest_nowrite: assert property (p_lowest_nowrite) else $error("lowest level filter write not refused");

  property p_miss;
    req.valid && !any_hit |=> rsp.ack && !rsp.hit && !rsp.undef && rsp.rdata == 64'h0;
  endproperty
  a_miss: assert property (p_miss) else $error("unmapped encoding answered");

  property p_write_zero;
    req.valid && req.write |=> rsp.ack && rsp.rdata == 64'h0;
  endproperty
  a_write_zero: assert property (p_write_zero) else $error("write returned data");

  property p_mask;
    (sample_event_filter & ~IMPL_MASK) == 64'h0;
  endproperty
  a_mask: assert property (p_mask) else $error("unimplemented filter bit set");

  property p_done;
    sample_valid |=> sample_done;
  endproperty
  a_done: assert property (p_done) else $error("sample not answered");

  property p_quiet;
    !sample_valid |=> !sample_done && !sample_keep;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer without sample");

  c_info: cover property (req.valid && info_hit && !lowest_el ##1 rsp.ack);
  c_undef: cover property (req.valid && info_hit && lowest_el ##1 rsp.undef);
  c_drop: cover property (sample_valid && filter_enable_bit ##1 sample_done && !sample_keep);
  c_filt_wr: cover property (filt_wr ##1 req.valid && !req.write && filt_hit);
  c_keep: cover property (sample_valid && filter_enable_bit ##1 sample_keep);

endmodule

`default_nettype wire

// File: hw/pfid_consts.svh
// constants for the profiling filter and buffer information register bank
// assumes inclusion by bare name from the register bank design file
`ifndef PFID_CONSTS_SVH
`define PFID_CONSTS_SVH

// ---------------------------------------------------------------
// system register encodings
// ---------------------------------------------------------------
`define PFID_OP0 2'h3
`define PFID_OP1 3'h0
`define PFID_CRN 4'h9
`define PFID_INFO_CRM 4'ha
`define PFID_INFO_OP2 3'h7
`define PFID_FILT_CRM 4'h9
`define PFID_FILT_OP2 3'h5
`define PFID_CAP_CRM 4'h9
`define PFID_CAP_OP2 3'h7

// ---------------------------------------------------------------
// buffer information fields
// ---------------------------------------------------------------
`define PFID_INFO_FLAG_BIT 5
`define PFID_INFO_FLAG_VAL 1'h1
`define PFID_INFO_PROG_BIT 4
`define PFID_INFO_ALIGN_LSB 0
`define PFID_INFO_ALIGN_VAL 4'h6

// ---------------------------------------------------------------
// levels and reset values
// ---------------------------------------------------------------
`define PFID_EL_LOWEST 2'h0
`define PFID_FILT_RESET 64'h0
`define PFID_IMPL_MASK 64'hffff_ffff_ffff_ffff
`define PFID_CAP_VALUE 64'h0

`endif

// File: hw/pfid_pkg.sv
// types shared by the profiling filter and buffer information bank
// assumes the constants header sits beside it
`default_nettype none

package pfid_pkg;

  // system register access request, one cycle wide
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    logic [1:0] el;
    logic [63:0] wdata;
  } pfid_req_t;

  // answer, one cycle after the request
  typedef struct packed {
    logic ack;
    logic hit;
    logic undef;
    logic [63:0] rdata;
  } pfid_rsp_t;

endpackage

`default_nettype wire

// File: hw/pfid_filter_bit.sv
// one event filter cell: passes unless the filter is armed and the event is absent
// assumes it is instantiated once per event by the register bank
`timescale 1ns/100ps
`default_nettype none

module pfid_filter_bit (
  // filter setting
  input wire logic armed,
  // event of the sample
  input wire logic event_seen,
  // result
  output logic pass
);

  assign pass = ~armed | event_seen;

endmodule

`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the profiling filter and buffer information bank
// assumes the package, header and design files are compiled first; assertions live in the design
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  // bits 62 and 7 unimplemented, so those filter bits must read zero
  localparam logic [63:0] MASK = 64'hbfff_ffff_ffff_ff7f;
  localparam logic [63:0] CAP = 64'h0000_0000_0000_0a5c;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  pfid_pkg::pfid_req_t req = '0;
  pfid_pkg::pfid_rsp_t rsp;
  logic boh = 1'b0;
  logic fe = 1'b0;
  logic sv = 1'b0;
  logic [63:0] ev = 64'h0;
  logic sample_done;
  logic sample_keep;
  logic [63:0] fval = 64'h0;
  logic [63:0] w;
  integer seed = 51;
  integer n_mismatch = 0;
  integer compares = 0;
  integer i;

  always #5 mclk = ~mclk;

  pfid_regs #(.IMPL_MASK(MASK), .CAP_VALUE(CAP)) uut (.mclk(mclk), .rst(rst), .req(req), .rsp(rsp),
    .buffer_owned_higher(boh), .filter_enable_bit(fe), .sample_valid(sv), .sample_events(ev),
    .sample_done(sample_done), .sample_keep(sample_keep));

  // ---------------------------------------------------------------
  // expectations and drivers
  // ---------------------------------------------------------------
  function automatic logic keep_exp(input logic en, input logic [63:0] f, input logic [63:0] e);
    return !en || ((f & ~e) == 64'h0);
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // valid stays high so calls run back to back; idle drops it
  task automatic acc(input logic wr, input logic [3:0] crm, input logic [2:0] op2, input logic [1:0] el,
                     input logic [63:0] wd, input logic [2:0] fl, input logic [63:0] rd);
    req = '{1'b1, wr, 2'h3, 3'h0, 4'h9, crm, op2, el, wd};
    @(posedge mclk);
    #1;
    chk({61'h0, rsp.ack, rsp.hit, rsp.undef}, {61'h0, fl});
    chk(rsp.rdata, rd);
  endtask

  task automatic wf(input logic [63:0] d);
    acc(1'b1, 4'h9, 3'h5, 2'h1, d, 3'b110, 64'h0);
    fval = d & MASK;
    acc(1'b0, 4'h9, 3'h5, 2'h2, 64'h0, 3'b110, fval);
  endtask

  task automatic smp(input logic en, input logic [63:0] e);
    sv = 1'b1;
    fe = en;
    ev = e;
    @(posedge mclk);
    #1;
    chk({63'h0, sample_done}, 64'h1);
    chk({63'h0, sample_keep}, {63'h0, keep_exp(en, fval, e)});
  endtask

  task automatic idle(input string name);
    req.valid = 1'b0;
    sv = 1'b0;
    @(posedge mclk);
    #1;
    chk({62'h0, rsp.ack, sample_done}, 64'h0);
    $display("test %s done", name);
  endtask

  task automatic give_verdict;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    #1;
    rst = 1'b0;
    acc(1'b0, 4'h9, 3'h5, 2'h1, 64'h0, 3'b110, 64'h0);
    for (i = 0; i < 8; i = i + 1) begin
      boh = i[2];
      acc(1'b0, 4'ha, 3'h7, i[1:0], 64'h0, (i[1:0] == 2'h0) ? 3'b111 : 3'b110,
          (i[1:0] == 2'h0) ? 64'h0 : {58'h0, 1'b1, boh, 4'h6});
    end
    acc(1'b1, 4'ha, 3'h7, 2'h3, 64'hffff_ffff_ffff_ffff, 3'b110, 64'h0);
    acc(1'b0, 4'ha, 3'h7, 2'h3, 64'h0, 3'b110, {58'h0, 1'b1, boh, 4'h6});
    acc(1'b0, 4'h9, 3'h7, 2'h2, 64'h0, 3'b110, CAP);
    acc(1'b0, 4'hb, 3'h7, 2'h1, 64'h0, 3'b100, 64'h0);
    acc(1'b1, 4'h9, 3'h5, 2'h0, 64'hffff_ffff_ffff_ffff, 3'b111, 64'h0);
    acc(1'b0, 4'h9, 3'h5, 2'h1, 64'h0, 3'b110, 64'h0);
    idle("access");
    // corners: top bit, events 3 and 5, unimplemented bits 62 and 7
    wf(64'h8000_0000_0000_0000);
    smp(1'b1, 64'h7fff_ffff_ffff_ffff);
    smp(1'b0, 64'h7fff_ffff_ffff_ffff);
    smp(1'b1, 64'h8000_0000_0000_0000);
    wf(64'h0000_0000_0000_0028);
    smp(1'b1, 64'h0000_0000_0000_0008);
    smp(1'b1, 64'h0000_0000_0000_0028);
    // a reset in mid-run clears the filter and silences both answers
    rst = 1'b1;
    sv = 1'b0;
    @(posedge mclk);
    #1;
    chk({62'h0, rsp.ack, sample_done}, 64'h0);
    rst = 1'b0;
    fval = 64'h0;
    acc(1'b0, 4'h9, 3'h5, 2'h1, 64'h0, 3'b110, 64'h0);
    wf(64'h4000_0000_0000_0080);
    smp(1'b1, 64'h0);
    idle("corner");
    for (i = 0; i < 20; i = i + 1) begin
      w = {$random(seed), $random(seed)};
      wf(w);
      smp(1'($random(seed)), {$random(seed), $random(seed)});
      w = fval | {$random(seed), $random(seed)};
      smp(1'b1, w);
      smp(1'b1, w & ~(64'h1 << ($random(seed) & 63)));
      idle("random");
    end
    give_verdict();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch = n_mismatch + 1;
    give_verdict();
  end
endmodule

`default_nettype wire
